// ### qdc_defines.svh
// Offsets, field positions and reset values of the queued command DMA context
`ifndef QDC_DEFINES_SVH
`define QDC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define QDC_OFS_CTRL     8'h00
`define QDC_OFS_ISSUE    8'h04
`define QDC_OFS_DONE     8'h08
`define QDC_OFS_TSEL     8'h0C
`define QDC_OFS_TPTR     8'h10
`define QDC_OFS_ISTAT    8'h14
`define QDC_OFS_IMASK    8'h18
`define QDC_OFS_SETUP    8'h1C
`define QDC_OFS_COUNT    8'h20
`define QDC_OFS_DEVSTAT  8'h24

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define QDC_IRQ_W        3
`define QDC_IRQ_DONE     0
`define QDC_IRQ_SETERR   1
`define QDC_IRQ_WALK     2

// ****************************************************************
// Frame payload layout
// ****************************************************************
`define QDC_FIS_SETUP    8'h41
`define QDC_FIS_SDB      8'hA1
`define QDC_FIS_ACT      8'h39
`define QDC_DIR_BIT      13
`define QDC_AUTO_BIT     15
`define QDC_TAG_WORD     3'h1
`define QDC_CNT_WORD     3'h5
`define QDC_LAST_IDX     3'h7

// ****************************************************************
// Descriptor layout and sizes
// ****************************************************************
`define QDC_NTAGS        32
`define QDC_DESC_EOT_BIT 31
`define QDC_DESC_LEN_W   22
`define QDC_DESC_STEP    32'h0000_0004
`define QDC_ZERO32       32'h0000_0000

`endif

// ### qdc_pkg.sv
// Types shared by the queued command DMA context
package qdc_pkg;

  // ****************************************************************
  // One word of a received frame payload
  // ****************************************************************
  typedef struct packed {
    logic        sof;
    logic        eof;
    logic        crcErr;
    logic [31:0] data;
  } qdc_rxword_type;

  // ****************************************************************
  // One memory segment handed to the data mover
  // ****************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [21:0] len;
    logic        last;
  } qdc_seg_type;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_ADDR,
    WK_LEN,
    WK_EMIT
  } qdc_walk_state_type;

endpackage

// ### qdc_desc_walk.sv
// Descriptor table walker: fetches address/length pairs until end of table
`timescale 1ns/1ps
`include "qdc_defines.svh"

module qdc_desc_walk (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Start request
  input  wire logic                  start,
  input  wire logic [31:0]           tablePtr,
  output logic                       busy_r,
  output logic                       done_r,
  // Descriptor memory read port
  output logic                       descReq_r,
  output logic [31:0]                descAddr_r,
  input  wire logic                  descAck,
  input  wire logic [31:0]           descData,
  // Segment output
  output logic                       segValid_r,
  output qdc_pkg::qdc_seg_type       seg_r,
  input  wire logic                  segReady
);

  qdc_pkg::qdc_walk_state_type state_r;
  logic [31:0]                 ptr_r;
  logic [31:0]                 nextPtr;

  // Each entry is two words: segment address, then flags and length
  assign nextPtr = ptr_r + `QDC_DESC_STEP + `QDC_DESC_STEP;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= qdc_pkg::WK_IDLE;
      ptr_r      <= `QDC_ZERO32;
      descReq_r  <= 1'b0;
      descAddr_r <= `QDC_ZERO32;
      segValid_r <= 1'b0;
      seg_r      <= '0;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        qdc_pkg::WK_IDLE: begin
          if (start) begin
            ptr_r      <= tablePtr;
            descAddr_r <= tablePtr;
            descReq_r  <= 1'b1;
            busy_r     <= 1'b1;
            state_r    <= qdc_pkg::WK_ADDR;
          end
        end
        qdc_pkg::WK_ADDR: begin
          if (descAck) begin
            seg_r.addr <= descData;
            descAddr_r <= ptr_r + `QDC_DESC_STEP;
            state_r    <= qdc_pkg::WK_LEN;
          end
        end
        qdc_pkg::WK_LEN: begin
          if (descAck) begin
            descReq_r  <= 1'b0;
            seg_r.len  <= descData[`QDC_DESC_LEN_W-1:0];
            seg_r.last <= descData[`QDC_DESC_EOT_BIT]; // RULE4
            segValid_r <= 1'b1;
            state_r    <= qdc_pkg::WK_EMIT;
          end
        end
        qdc_pkg::WK_EMIT: begin
          if (segReady) begin
            segValid_r <= 1'b0;
            if (seg_r.last) begin
              // Stop after the flagged entry, never read past it
              busy_r  <= 1'b0; // RULE4
              done_r  <= 1'b1;
              state_r <= qdc_pkg::WK_IDLE;
            end else begin
              ptr_r      <= nextPtr;
              descAddr_r <= nextPtr;
              descReq_r  <= 1'b1;
              state_r    <= qdc_pkg::WK_ADDR;
            end
          end
        end
        default: state_r <= qdc_pkg::WK_IDLE;
      endcase
    end
  end

endmodule

// ### qdc_queue_ctx.sv
// Queued command tracking and first-party DMA context loading, APB slave
//
// Overview of operation
// (RULE1) Each queued command is known by its tag in data and completion phase.
// (RULE2) The drive names the next tag to transfer with a setup frame.
// (RULE3) A setup frame loads the walker with that tag's descriptor table.
// (RULE4) The walker reads address/length entries and stops after end-of-table.
// (RULE5) A frame is delimiter, payload, CRC, delimiter; bad CRC is dropped.
// (RULE6) The drive completes commands by sending their tags plus status.
// (RULE7) Completions and setups for outstanding tags are taken in any order.
// (RULE8) Both setup frames and set-device-bits frames are received.
// (RULE9) Up to 32 outstanding commands are tracked, one per tag.
// (RULE10) Queued handling is switched on per port by a control bit.
// (RULE11) Only queued read and write exist; direction arrives with setup.
// (RULE12) Only existing frame types are recognised; no new mechanisms.
// (RULE13) Software issues queued commands only to drives advertising support.
// (RULE14) Set-device-bits completes every tag whose bit is one; interrupts.
// (RULE15) Auto-activate on a queued write starts data without activate frame.
// (RULE16) Direction and byte count come from the setup frame alone.
// (RULE17) A setup frame is handled in hardware and raises no interrupt; a refused one sets SETERR here.
// (RULE18) A setup for a tag not outstanding is refused and flagged.
`timescale 1ns/1ps
`include "qdc_defines.svh"

module qdc_queue_ctx (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata_r,
  output logic                       pready_r,
  output logic                       pslverr_r,
  // Interrupt
  output logic                       irq_r,
  // Received frame payload from the link layer
  input  wire logic                  rxValid,
  input  wire qdc_pkg::qdc_rxword_type rxWord,
  // Transfer launch to the data mover
  output logic                       xferGo_r,
  output logic                       xferDir_r,
  output logic [31:0]                xferCount_r,
  output logic [4:0]                 xferTag_r,
  // Descriptor memory read port
  output logic                       descReq_r,
  output logic [31:0]                descAddr_r,
  input  wire logic                  descAck,
  input  wire logic [31:0]           descData,
  // Segment stream
  output logic                       segValid_r,
  output qdc_pkg::qdc_seg_type       seg_r,
  input  wire logic                  segReady
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                  qEnable_r;
  logic [31:0]           outstanding_r;
  logic [31:0]           done_r;
  logic [31:0]           ptrTable_r [0:`QDC_NTAGS-1];
  logic [4:0]            tagSel_r;
  logic [`QDC_IRQ_W-1:0] istat_r;
  logic [`QDC_IRQ_W-1:0] imask_r;
  logic [`QDC_IRQ_W-1:0] irqEvent;
  logic [2:0]            wordIdx_r;
  logic [31:0]           word0_r;
  logic [31:0]           word1_r;
  logic [31:0]           word5_r;
  logic                  fisDone_r;
  logic                  isSetup;
  logic                  isSdb;
  logic                  isAct;
  logic                  setupOk;
  logic                  setupBad;
  logic [4:0]            setupTag;
  logic [31:0]           setupPtr;
  logic                  setupDir;
  logic                  setupAuto;
  logic                  setupErr_r;
  logic                  xferPend_r;
  logic [31:0]           sdbClr;
  logic [7:0]            devStat_r;
  logic [7:0]            devErr_r;
  logic                  walkStart_r;
  logic [31:0]           walkPtr_r;
  logic                  walkBusy;
  logic                  walkDone;
  logic                  access;
  logic                  wrEn;
  logic                  hit;
  logic [31:0]           rdMux;

  // ****************************************************************
  // APB slave: one wait state, answer on the second access cycle
  // ****************************************************************
  assign access = psel && penable;
  assign wrEn   = access && pwrite && pready_r;

  always_comb begin
    hit   = 1'b1;
    rdMux = `QDC_ZERO32;
    if (paddr == `QDC_OFS_CTRL) begin
      rdMux = {31'h0000_0000, qEnable_r};
    end else if (paddr == `QDC_OFS_ISSUE) begin
      rdMux = outstanding_r;
    end else if (paddr == `QDC_OFS_DONE) begin
      rdMux = done_r;
    end else if (paddr == `QDC_OFS_TSEL) begin
      rdMux = {27'h000_0000, tagSel_r};
    end else if (paddr == `QDC_OFS_TPTR) begin
      rdMux = ptrTable_r[tagSel_r];
    end else if (paddr == `QDC_OFS_ISTAT) begin
      rdMux = {29'h0000_0000, istat_r};
    end else if (paddr == `QDC_OFS_IMASK) begin
      rdMux = {29'h0000_0000, imask_r};
    end else if (paddr == `QDC_OFS_SETUP) begin
      rdMux = {24'h00_0000, setupErr_r, xferPend_r, xferDir_r, xferTag_r};
    end else if (paddr == `QDC_OFS_COUNT) begin
      rdMux = xferCount_r;
    end else if (paddr == `QDC_OFS_DEVSTAT) begin
      rdMux = {16'h0000, devErr_r, devStat_r};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `QDC_ZERO32;
    end else begin
      pready_r  <= access && !pready_r;
      pslverr_r <= access && !pready_r && !hit;
      prdata_r  <= (access && !pready_r && !pwrite) ? rdMux : `QDC_ZERO32;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qEnable_r <= 1'b0;
      tagSel_r  <= 5'h00;
      imask_r   <= '0;
    end else if (wrEn) begin
      if (paddr == `QDC_OFS_CTRL) begin
        qEnable_r <= pwdata[0]; // RULE10
      end else if (paddr == `QDC_OFS_TSEL) begin
        tagSel_r <= pwdata[4:0];
      end else if (paddr == `QDC_OFS_IMASK) begin
        imask_r <= pwdata[`QDC_IRQ_W-1:0];
      end
    end
  end

  // One descriptor table pointer per tag
  for (genvar g = 0; g < `QDC_NTAGS; g++) begin : gTable
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ptrTable_r[g] <= `QDC_ZERO32;
      end else if (wrEn && paddr == `QDC_OFS_TPTR && tagSel_r == 5'(g)) begin
        ptrTable_r[g] <= pwdata; // RULE9
      end
    end
  end

  // ****************************************************************
  // Frame payload capture
  // ****************************************************************
  // Link layer already stripped delimiters and checked the CRC; a frame
  // whose CRC failed is dropped here and never acted on.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wordIdx_r <= 3'h0;
      word0_r   <= `QDC_ZERO32;
      word1_r   <= `QDC_ZERO32;
      word5_r   <= `QDC_ZERO32;
      fisDone_r <= 1'b0;
    end else begin
      fisDone_r <= rxValid && rxWord.eof && !rxWord.crcErr; // RULE5
      if (rxValid) begin
        if (rxWord.sof) begin
          word0_r   <= rxWord.data;
          wordIdx_r <= 3'h1;
        end else begin
          if (wordIdx_r == `QDC_TAG_WORD) begin
            word1_r <= rxWord.data;
          end
          if (wordIdx_r == `QDC_CNT_WORD) begin
            word5_r <= rxWord.data;
          end
          if (wordIdx_r != `QDC_LAST_IDX) begin
            wordIdx_r <= wordIdx_r + 3'h1;
          end
        end
      end
    end
  end

  // Only the setup, set-device-bits and activate types are decoded
  assign isSetup   = fisDone_r && word0_r[7:0] == `QDC_FIS_SETUP; // RULE12
  assign isSdb     = fisDone_r && word0_r[7:0] == `QDC_FIS_SDB;   // RULE8
  assign isAct     = fisDone_r && word0_r[7:0] == `QDC_FIS_ACT;
  assign setupTag  = word1_r[4:0];
  assign setupPtr  = ptrTable_r[setupTag];
  assign setupDir  = word0_r[`QDC_DIR_BIT];
  assign setupAuto = word0_r[`QDC_AUTO_BIT];
  // A tag the host never issued must not steer DMA into memory
  assign setupOk   = isSetup && qEnable_r && outstanding_r[setupTag] &&
                     !walkBusy && !walkStart_r; // RULE18 RULE7
  assign setupBad  = isSetup && qEnable_r && !setupOk; // RULE18
  assign sdbClr    = (isSdb && qEnable_r) ? word1_r : `QDC_ZERO32; // RULE14

  // ****************************************************************
  // Outstanding and completed tags
  // ****************************************************************
  // Both read and write queued commands set the same bit; the direction
  // is not recorded here since the setup frame carries it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outstanding_r <= `QDC_ZERO32;
    end else if (wrEn && paddr == `QDC_OFS_ISSUE) begin
      outstanding_r <= (outstanding_r & ~sdbClr) | pwdata; // RULE1 RULE11
    end else begin
      outstanding_r <= outstanding_r & ~sdbClr; // RULE6 RULE7
    end
  end

  // Completion set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= `QDC_ZERO32;
    end else if (wrEn && paddr == `QDC_OFS_DONE) begin
      done_r <= (done_r & ~pwdata) | sdbClr; // RULE14
    end else begin
      done_r <= done_r | sdbClr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      devStat_r <= 8'h00;
      devErr_r  <= 8'h00;
    end else if (isSdb) begin
      devStat_r <= word0_r[23:16]; // RULE6
      devErr_r  <= word0_r[31:24];
    end
  end

  // ****************************************************************
  // Context load and transfer launch
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      walkStart_r <= 1'b0;
      walkPtr_r   <= `QDC_ZERO32;
      xferGo_r    <= 1'b0;
      xferPend_r  <= 1'b0;
      xferDir_r   <= 1'b0;
      xferCount_r <= `QDC_ZERO32;
      xferTag_r   <= 5'h00;
      setupErr_r  <= 1'b0;
    end else begin
      walkStart_r <= setupOk; // RULE2
      xferGo_r    <= 1'b0;
      if (setupOk) begin
        walkPtr_r   <= setupPtr;  // RULE3
        xferDir_r   <= setupDir;  // RULE16
        xferCount_r <= word5_r;   // RULE16
        xferTag_r   <= setupTag;
        setupErr_r  <= 1'b0;
        // Device-to-host needs no activate; auto-activate skips it too
        xferGo_r    <= setupDir || setupAuto; // RULE15
        xferPend_r  <= !(setupDir || setupAuto);
      end else if (isAct && xferPend_r) begin
        xferGo_r   <= 1'b1;
        xferPend_r <= 1'b0;
      end else if (setupBad) begin
        setupErr_r <= 1'b1; // RULE18
      end
    end
  end

  // ****************************************************************
  // Interrupts: sticky status, write one to clear, set wins
  // ****************************************************************
  // Accepted setup frames never appear here; only a refused one is reported
  assign irqEvent = {walkDone, setupBad, isSdb}; // RULE14 RULE17

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      if (wrEn && paddr == `QDC_OFS_ISTAT) begin
        istat_r <= (istat_r & ~pwdata[`QDC_IRQ_W-1:0]) | irqEvent;
      end else begin
        istat_r <= istat_r | irqEvent;
      end
      irq_r <= |(istat_r & imask_r);
    end
  end

  qdc_desc_walk uWalk (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .start      (walkStart_r),
    .tablePtr   (walkPtr_r),
    .busy_r     (walkBusy),
    .done_r     (walkDone),
    .descReq_r  (descReq_r),
    .descAddr_r (descAddr_r),
    .descAck    (descAck),
    .descData   (descData),
    .segValid_r (segValid_r),
    .seg_r      (seg_r),
    .segReady   (segReady)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sApbAccess;
    access && !pready_r;
  endsequence
  sequence sSdbSeen;
    isSdb && imask_r[`QDC_IRQ_DONE] && !(wrEn && paddr == `QDC_OFS_IMASK);
  endsequence

  a_apb_one_wait: assert property (sApbAccess |=> pready_r ##1 !pready_r)
    else $error("APB answer not one cycle after access start");
  a_setup_load_ptr: assert property (setupOk |=> // RULE3
      walkStart_r && walkPtr_r == $past(setupPtr) ##1 walkBusy)
    else $error("Setup did not load the tag's table pointer");
  a_setup_dir_count: assert property (setupOk |=> // RULE16
      xferDir_r == $past(setupDir) && xferCount_r == $past(word5_r))
    else $error("Direction or count not taken from setup frame");
  a_auto_activate_go: assert property ( // RULE15
      setupOk && (setupDir || setupAuto) |=> xferGo_r && !xferPend_r)
    else $error("Transfer did not start without activate frame");
  a_setup_no_irq: assert property (setupOk |=> // RULE17
      istat_r == ($past(istat_r) | {$past(walkDone), 2'b00}) ||
      $past(wrEn))
    else $error("Accepted setup changed interrupt status");
  a_bad_tag_refused: assert property (setupBad |=> // RULE18
      istat_r[`QDC_IRQ_SETERR] && !walkStart_r && setupErr_r)
    else $error("Setup for idle tag was not refused");
  a_sdb_irq_path: assert property (sSdbSeen |=> // RULE14
      istat_r[`QDC_IRQ_DONE] ##1 irq_r)
    else $error("Completion frame did not raise interrupt");
  a_sdb_completes: assert property (isSdb && qEnable_r |=> // RULE7
      (done_r & $past(word1_r)) == $past(word1_r) &&
      (outstanding_r & $past(word1_r) & ~$past(pwdata)) == `QDC_ZERO32)
    else $error("Completed tags not retired");
  a_disabled_ignore: assert property (isSetup && !qEnable_r |=> // RULE10
      !walkStart_r && !xferGo_r)
    else $error("Setup acted on while queuing disabled");
  a_walk_stop_last: assert property ( // RULE4
      segValid_r && segReady && seg_r.last |=> walkDone && !descReq_r
      ##1 !walkBusy)
    else $error("Walker did not stop after end-of-table entry");
  a_bad_crc_drop: assert property ( // RULE5
      rxValid && rxWord.eof && rxWord.crcErr |=> !fisDone_r)
    else $error("Frame with CRC error was acted on");

endmodule

// ### qdc_drive_model.sv
// Behavioural drive that sends frame payloads toward the host side
`timescale 1ns/1ps

module qdc_drive_model (
  // Clock
  input  wire logic               clk_sys,
  // Frame payload toward the host
  output logic                    rxValid,
  output qdc_pkg::qdc_rxword_type rxWord
);
  initial begin
    rxValid = 1'b0;
    rxWord  = '0;
  end

  // ********
  // Frame sender
  // ********
  // Delimiters and CRC are stripped below us; crcBad marks a failed CRC
  task automatic send(input logic [31:0] w0, input logic [31:0] w1,
                      input logic [31:0] w5, input logic crcBad);
    logic [31:0] w;
    w = w0;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      w = (i == 0) ? w0 : (i == 1) ? w1 : (i == 5) ? w5 : 32'h0000_0000;
      rxValid <= 1'b1;
      rxWord  <= '{(i == 0), (i == 6), crcBad & (i == 6), w};
    end
    @(posedge clk_sys);
    rxValid <= 1'b0;
    // Idle data never repeats the last word
    rxWord  <= '{1'b0, 1'b0, 1'b0, ~w};
  endtask
endmodule

// ### queued_command_dma_context_bench.sv
// Self-checking bench for the queued command DMA context
`timescale 1ns/1ps
`include "qdc_defines.svh"

module queued_command_dma_context_bench;
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [7:0]              paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [31:0]             prdata_r;
  logic                    pready_r, pslverr_r, irq_r, lastErr;
  logic                    rxValid, xferGo_r, xferDir_r, descReq_r;
  logic [31:0]             xferCount_r, descAddr_r;
  logic [4:0]              xferTag_r;
  logic                    segValid_r;
  logic                    descAck = 1'b0;
  logic                    segReady = 1'b0;
  logic [31:0]             descData = 32'h0000_0000;
  qdc_pkg::qdc_rxword_type rxWord;
  qdc_pkg::qdc_seg_type    seg_r;
  qdc_pkg::qdc_seg_type    segQ[$];
  logic [31:0]             mem [4] = '{32'h0000_2000, 32'h0000_0040,
                                       32'h0000_3000, 32'h8000_0080};
  logic [4:0]              goTag;
  logic                    goDir;
  logic [31:0]             goBytes;
  int                      n_mismatch = 0;
  int                      n_tests = 0;
  int                      goCnt = 0;

  always #20 clk_sys = ~clk_sys;

  qdc_queue_ctx u_qdc_queue_ctx (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .irq_r(irq_r), .rxValid(rxValid),
    .rxWord(rxWord), .xferGo_r(xferGo_r), .xferDir_r(xferDir_r),
    .xferCount_r(xferCount_r), .xferTag_r(xferTag_r),
    .descReq_r(descReq_r), .descAddr_r(descAddr_r), .descAck(descAck),
    .descData(descData), .segValid_r(segValid_r), .seg_r(seg_r),
    .segReady(segReady));

  qdc_drive_model u_drive (.clk_sys(clk_sys), .rxValid(rxValid),
    .rxWord(rxWord));

  // ********
  // Host memory, segment sink and launch monitor
  // ********
  // The sink stalls every other cycle to exercise the segment handshake
  always @(posedge clk_sys) begin
    descAck  <= descReq_r & ~descAck;
    descData <= descReq_r ? mem[descAddr_r[3:2]] : ~descData;
    segReady <= ~segReady;
    if (segValid_r === 1'b1 && segReady) segQ.push_back(seg_r);
    if (xferGo_r === 1'b1) begin
      goCnt++;
      goTag = xferTag_r;
      goDir = xferDir_r;
      goBytes = xferCount_r;
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready_r !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h0000_0001, 32'h0000_0000);
    q = prdata_r;
    lastErr = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask

  task automatic frame(input logic [31:0] w0, w1, w5, input logic bad);
    u_drive.send(w0, w1, w5, bad);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic waitseg(input int k);
    for (int n = 0; n < 300 && segQ.size() < k; n++) @(posedge clk_sys);
    chk("segments", k, segQ.size());
  endtask

  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    logic [31:0] q;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`QDC_OFS_CTRL, 32'h0000_0000, "ctrl");
    rd(`QDC_OFS_ISTAT, 32'h0000_0000, "istat");
    apb(1'b0, 8'h3C, 32'h0000_0000, q);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, lastErr});
    wr(`QDC_OFS_CTRL, 32'h0000_0001);
    wr(`QDC_OFS_ISSUE, 32'h0000_0028);
    wr(`QDC_OFS_TSEL, 32'h0000_0003);
    wr(`QDC_OFS_TPTR, 32'h0000_0100);
    wr(`QDC_OFS_TSEL, 32'h0000_0005);
    wr(`QDC_OFS_TPTR, 32'h0000_0100);
    rd(`QDC_OFS_ISSUE, 32'h0000_0028, "issue");
    wr(`QDC_OFS_IMASK, 32'h0000_0000);
    frame(32'h0000_2041, 32'h0000_0007, 32'h0000_0010, 1'b0);
    rd(`QDC_OFS_ISTAT, 32'h0000_0002, "istat refuse");
    apb(1'b0, `QDC_OFS_SETUP, 32'h0000_0000, q);
    chk("setup err", 32'h0000_0001, {31'h0000_0000, q[7]});
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq_r});
    wr(`QDC_OFS_IMASK, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk("irq on", 32'h0000_0001, {31'h0000_0000, irq_r});
    wr(`QDC_OFS_ISTAT, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk("irq clear", 32'h0000_0000, {31'h0000_0000, irq_r});
    wr(`QDC_OFS_IMASK, 32'h0000_0007);
    frame(32'h0000_2041, 32'h0000_0003, 32'h0000_1000, 1'b0);
    waitseg(2);
    chk("go tag", 32'h0000_0003, {27'h000_0000, goTag});
    chk("go dir", 32'h0000_0001, {31'h0000_0000, goDir});
    chk("go bytes", 32'h0000_1000, goBytes);
    rd(`QDC_OFS_ISTAT, 32'h0000_0004, "istat walk");
    wr(`QDC_OFS_ISTAT, 32'h0000_0004);
    frame(32'h0000_0041, 32'h0000_0005, 32'h0000_0200, 1'b0);
    // Walker still busy with tag 5: a second setup must be refused
    frame(32'h0000_2041, 32'h0000_0003, 32'h0000_0010, 1'b0);
    rd(`QDC_OFS_SETUP, 32'h0000_00C5, "setup busy");
    wr(`QDC_OFS_ISTAT, 32'h0000_0002);
    chk("no go", 32'h0000_0001, 32'(goCnt));
    frame(32'h0000_0039, 32'h0000_0000, 32'h0000_0000, 1'b0);
    chk("go act", 32'h0000_0002, 32'(goCnt));
    chk("go tag5", 32'h0000_0005, {27'h000_0000, goTag});
    chk("go bytes5", 32'h0000_0200, goBytes);
    waitseg(4);
    for (int i = 0; i < 4; i++) begin
      chk("seg addr", i % 2 ? 32'h0000_3000 : 32'h0000_2000,
          segQ[i].addr);
      chk("seg len", i % 2 ? 32'h0000_0101 : 32'h0000_0080,
          {9'h000, segQ[i].len, segQ[i].last});
    end
    frame(32'h0040_00A1, 32'h0000_0028, 32'h0000_0000, 1'b1);
    rd(`QDC_OFS_DONE, 32'h0000_0000, "done crc");
    frame(32'h0040_00A1, 32'h0000_0020, 32'h0000_0000, 1'b0);
    frame(32'h0040_00A1, 32'h0000_0008, 32'h0000_0000, 1'b0);
    rd(`QDC_OFS_DONE, 32'h0000_0028, "done");
    rd(`QDC_OFS_ISSUE, 32'h0000_0000, "issue left");
    rd(`QDC_OFS_ISTAT, 32'h0000_0005, "istat sdb");
    rd(`QDC_OFS_DEVSTAT, 32'h0000_0040, "devstat");
    chk("irq sdb", 32'h0000_0001, {31'h0000_0000, irq_r});
    wr(`QDC_OFS_CTRL, 32'h0000_0000);
    wr(`QDC_OFS_ISSUE, 32'h0000_0001);
    frame(32'h0000_2041, 32'h0000_0000, 32'h0000_0010, 1'b0);
    chk("go off", 32'h0000_0002, 32'(goCnt));
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
endmodule
